// file: char_lcd_i2c_write_port.sv
// Two-wire write-only slave port of a character display controller with an APB register window.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "lcd_port_map.svh"
module char_lcd_i2c_write_port #(
  parameter int RAM_DEPTH = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  function automatic logic [6:0] ptr_step(input logic [6:0] p, input logic inc);
    ptr_step = inc ? p + 7'h01 : p - 7'h01;
  endfunction
  function automatic logic [7:0] ram_index(input lcd_port_pkg::ram_target_e t, input logic [6:0] p);
    case (t)
      lcd_port_pkg::tgt_glyph: ram_index = {2'h2, p[5:0]};
      lcd_port_pkg::tgt_icon: ram_index = {4'hC, p[3:0]};
      default: ram_index = {1'b0, p};
    endcase
  endfunction
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  lcd_port_pkg::link_state_e state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic sda_oe_n_reg;
  logic cont_reg;
  logic rs_reg;
  logic [7:0] data_holding_reg;
  logic [7:0] instruction_holding_reg;
  logic dr_pend_reg;
  logic ir_pend_reg;
  logic [6:0] ram_pointer_reg;
  lcd_port_pkg::ram_target_e target_reg;
  logic entry_inc_reg;
  logic ext_set_reg;
  logic bus_width_select_reg;
  logic [7:0] ram_mem [0:RAM_DEPTH-1];
  logic enable_reg;
  logic [7:0] ram_addr_reg;
  logic [15:0] bytes_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_val;
  logic mapped;
  // The first stage of each synchroniser feeds only the second one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end
  // A level counts only once the last two stages agree, which rejects one-cycle glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end
  wire scl_rise = scl_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_reg & scl_prev_reg;
  wire start_det = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  wire stop_det = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  wire in_byte = state_reg == lcd_port_pkg::st_addr || state_reg == lcd_port_pkg::st_ctrl ||
                 state_reg == lcd_port_pkg::st_payload;
  wire byte_end = scl_fall && bit_cnt_reg == `BYTE_BITS && sda_oe_n_reg && in_byte;
  wire addr_ok = shift_reg[7:1] == `SLAVE_ADDR && !shift_reg[0] && enable_reg;
  wire take = byte_end && (state_reg != lcd_port_pkg::st_addr || addr_ok);
  wire pay_take = byte_end && state_reg == lcd_port_pkg::st_payload;
  // Bits are shifted on the clock rise while a byte phase is open, up to eight per byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end else if (start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && in_byte && bit_cnt_reg < `BYTE_BITS) begin
      shift_reg <= {shift_reg[6:0], sda_reg};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else if (scl_fall && !sda_oe_n_reg) begin
      bit_cnt_reg <= 4'h0;
    end
  end
  // The acknowledge is given on reception alone, except that an address byte needs own address, write and enable; queued work never holds it back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe_n_reg <= 1'b1;
    end else if (start_det || stop_det) begin
      sda_oe_n_reg <= 1'b1;
    end else if (take) begin
      sda_oe_n_reg <= 1'b0;
    end else if (scl_fall && !sda_oe_n_reg) begin
      sda_oe_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lcd_port_pkg::st_idle;
      cont_reg <= 1'b0;
      rs_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= lcd_port_pkg::st_addr;
    end else if (stop_det) begin
      state_reg <= lcd_port_pkg::st_idle;
    end else if (byte_end) begin
      case (state_reg)
        lcd_port_pkg::st_addr: state_reg <= addr_ok ? lcd_port_pkg::st_ctrl : lcd_port_pkg::st_skip;
        lcd_port_pkg::st_ctrl: begin
          cont_reg <= shift_reg[7];
          rs_reg <= shift_reg[6];
          state_reg <= lcd_port_pkg::st_payload;
        end
        lcd_port_pkg::st_payload: state_reg <= cont_reg ? lcd_port_pkg::st_ctrl : lcd_port_pkg::st_payload;
        default: state_reg <= lcd_port_pkg::st_skip;
      endcase
    end
  end
  // Payload lands in one of the two holding registers and is acted on a cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_holding_reg <= 8'h00;
      instruction_holding_reg <= 8'h00;
      dr_pend_reg <= 1'b0;
      ir_pend_reg <= 1'b0;
    end else begin
      dr_pend_reg <= pay_take && rs_reg;
      ir_pend_reg <= pay_take && !rs_reg;
      if (pay_take && rs_reg) begin
        data_holding_reg <= shift_reg;
      end
      if (pay_take && !rs_reg) begin
        instruction_holding_reg <= shift_reg;
      end
    end
  end
  // Clear display homes the pointer and restores incrementing entry; the RAM itself is not refilled here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_pointer_reg <= `PTR_RESET;
      target_reg <= lcd_port_pkg::tgt_disp;
      entry_inc_reg <= 1'b1;
      ext_set_reg <= 1'b0;
      bus_width_select_reg <= 1'b1;
    end else if (ir_pend_reg) begin
      casez (instruction_holding_reg)
        8'b1???_????: begin
          target_reg <= lcd_port_pkg::tgt_disp;
          ram_pointer_reg <= instruction_holding_reg[6:0];
        end
        8'b01??_????: begin
          if (ext_set_reg) begin
            target_reg <= lcd_port_pkg::tgt_icon;
            ram_pointer_reg <= {3'h0, instruction_holding_reg[3:0]};
          end else begin
            target_reg <= lcd_port_pkg::tgt_glyph;
            ram_pointer_reg <= {1'b0, instruction_holding_reg[5:0]};
          end
        end
        8'b001?_????: begin
          bus_width_select_reg <= instruction_holding_reg[4];
          ext_set_reg <= instruction_holding_reg[0];
        end
        8'b0000_01??: begin
          entry_inc_reg <= instruction_holding_reg[1];
        end
        8'b0000_001?: begin
          target_reg <= lcd_port_pkg::tgt_disp;
          ram_pointer_reg <= `PTR_RESET;
        end
        `CMD_CLEAR: begin
          target_reg <= lcd_port_pkg::tgt_disp;
          ram_pointer_reg <= `PTR_RESET;
          entry_inc_reg <= 1'b1;
        end
        default: ram_pointer_reg <= ram_pointer_reg;
      endcase
    end else if (dr_pend_reg) begin
      ram_pointer_reg <= ptr_step(ram_pointer_reg, entry_inc_reg);
    end
  end
  always_ff @(posedge pclk) begin
    if (dr_pend_reg) begin
      ram_mem[ram_index(target_reg, ram_pointer_reg)] <= data_holding_reg;
    end
  end
  wire apb_acc = psel && penable && !pready_reg;
  wire apb_done = psel && penable && pready_reg;
  always_comb begin
    mapped = paddr[1:0] == 2'h0 && paddr <= `OFS_RAM_DATA;
    case (paddr)
      `OFS_CTRL: rd_val = {31'h0, enable_reg};
      `OFS_STATUS: rd_val = {15'h0, state_reg != lcd_port_pkg::st_idle, 1'b0, bus_width_select_reg,
                             ext_set_reg, entry_inc_reg, 2'h0, target_reg, 1'b0, ram_pointer_reg};
      `OFS_BYTES: rd_val = {16'h0, bytes_reg};
      `OFS_RAM_ADDR: rd_val = {24'h0, ram_addr_reg};
      `OFS_RAM_DATA: rd_val = {24'h0, ram_mem[ram_addr_reg]};
      default: rd_val = 32'h0;
    endcase
  end
  // Every access takes one wait state; writes land at the completing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_acc;
      pslverr_reg <= apb_acc && !mapped;
      prdata_reg <= (apb_acc && !pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `CTRL_RESET;
      ram_addr_reg <= `RAM_ADDR_RESET;
    end else if (apb_done && pwrite) begin
      if (paddr == `OFS_CTRL) begin
        enable_reg <= pwdata[`CTRL_ENABLE_BIT];
      end
      if (paddr == `OFS_RAM_ADDR) begin
        ram_addr_reg <= pwdata[7:0];
      end
    end
  end
  // A byte arriving with a software clear still counts, so no reception is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bytes_reg <= 16'h0;
    end else if (apb_done && pwrite && paddr == `OFS_BYTES) begin
      bytes_reg <= take ? 16'h1 : 16'h0;
    end else if (take) begin
      bytes_reg <= bytes_reg + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end
  assign sda_oe_n = sda_oe_n_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_data_byte;
    pay_take && rs_reg;
  endsequence
  sequence s_ram_step;
    dr_pend_reg ##1 ram_pointer_reg == ptr_step($past(ram_pointer_reg), $past(entry_inc_reg));
  endsequence
  a_addr_ack: assert property (byte_end && state_reg == lcd_port_pkg::st_addr && addr_ok |=> !sda_oe_n_reg)
    else $error("own address not acknowledged");
  a_foreign_nack: assert property (byte_end && state_reg == lcd_port_pkg::st_addr && !addr_ok |=>
                                   sda_oe_n_reg && state_reg == lcd_port_pkg::st_skip)
    else $error("foreign address or read was acknowledged");
  a_ack_held: assert property (!sda_oe_n_reg && !scl_fall && !start_det && !stop_det |=> !sda_oe_n_reg)
    else $error("acknowledge released early");
  a_drive_only_ack: assert property (!sda_oe_n_reg |-> bit_cnt_reg == `BYTE_BITS)
    else $error("data line driven outside acknowledge slot");
  a_start_addr: assert property (start_det |=> state_reg == lcd_port_pkg::st_addr && bit_cnt_reg == 4'h0)
    else $error("start did not open address phase");
  a_stop_idle: assert property (stop_det && !start_det |=> state_reg == lcd_port_pkg::st_idle && sda_oe_n_reg)
    else $error("stop did not end transfer");
  a_bit_count: assert property (scl_rise && in_byte && bit_cnt_reg < `BYTE_BITS && !start_det && !stop_det |=>
                                bit_cnt_reg == $past(bit_cnt_reg) + 4'h1)
    else $error("bit not counted on clock rise");
  a_ram_store: assert property (s_data_byte |=> s_ram_step)
    else $error("data byte did not step the pointer");
  a_cmd_hold: assert property (pay_take && !rs_reg |=> ir_pend_reg && instruction_holding_reg == $past(shift_reg))
    else $error("command byte not held for decode");
  a_ctrl_fields: assert property (byte_end && state_reg == lcd_port_pkg::st_ctrl && !start_det && !stop_det |=>
                                  state_reg == lcd_port_pkg::st_payload && cont_reg == $past(shift_reg[7]))
    else $error("control byte fields not captured");
endmodule

// file: lcd_port_map.svh
// Register offsets, reset values and link constants of the display write port.
`ifndef LCD_PORT_MAP_SVH
`define LCD_PORT_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_BYTES 8'h08
`define OFS_RAM_ADDR 8'h0C
`define OFS_RAM_DATA 8'h10
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'b1
`define RAM_ADDR_RESET 8'h00
`define SLAVE_ADDR 7'h3E
`define BYTE_BITS 4'h8
`define PTR_RESET 7'h00
`define CMD_CLEAR 8'h01
`endif

// file: lcd_port_pkg.sv
// Types shared by the display write port.
package lcd_port_pkg;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_addr = 5'h02,
    st_ctrl = 5'h04,
    st_payload = 5'h08,
    st_skip = 5'h10
  } link_state_e;
  typedef enum logic [1:0] {
    tgt_disp = 2'h0,
    tgt_glyph = 2'h1,
    tgt_icon = 2'h2
  } ram_target_e;
endpackage

// file: i2c_host_model.sv
// Behavioural two-wire bus master that drives the display port's serial link.
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic pclk,
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda
);
  // A quarter of the 400 ns link period in clock cycles; the lines only move just after a rising edge.
  // The ack slot is stretched so that the slave's filtered release never races the next bit.
  localparam int q = 2;
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic start();
    tick(1);
    sda_oe_n <= 1'b0;
    tick(q);
    scl <= 1'b0;
    tick(q);
  endtask
  task automatic stop();
    sda_oe_n <= 1'b0;
    tick(q);
    scl <= 1'b1;
    tick(q);
    sda_oe_n <= 1'b1;
    tick(4*q);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic a0;
    for (int i = 7; i >= 0; i--) begin
      sda_oe_n <= b[i];
      tick(q);
      scl <= 1'b1;
      tick(2*q);
      scl <= 1'b0;
      tick(q);
    end
    sda_oe_n <= 1'b1;
    tick(2*q);
    scl <= 1'b1;
    tick(1);
    a0 = sda;
    tick(2*q-1);
    ack = !a0 && !sda;
    scl <= 1'b0;
    tick(2*q);
  endtask
endmodule

// file: tb_char_lcd_i2c_write_port.sv
// Self-checking bench for the display write port: APB register checks and two-wire frames.
`timescale 1ns/1ps
`include "lcd_port_map.svh"
module tb_char_lcd_i2c_write_port;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sda_out, sda_oe_n, scl, m_oe_n;
  wire sda_w;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Open-drain wire with a pull-up: low whenever either party pulls.
  assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & m_oe_n;
  char_lcd_i2c_write_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  i2c_host_model m (.pclk(pclk), .scl(scl), .sda_oe_n(m_oe_n), .sda(sda_w));
  always #25 pclk = ~pclk;
  task automatic results();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check($sformatf("reg %h", a), q, exp);
    check("slverr", {31'h0, e}, {31'h0, (a > `OFS_RAM_DATA) || (a[1:0] != 2'h0)});
  endtask
  task automatic xfer(input logic [7:0] bs[$], input logic acked);
    logic a;
    m.start();
    foreach (bs[i]) begin
      m.put_byte(bs[i], a);
      check("ack", {31'h0, a}, {31'h0, acked});
    end
    m.stop();
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(`OFS_CTRL, 32'h1);
    rdc(`OFS_STATUS, 32'h5000);
    rdc(`OFS_BYTES, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(8'h06, 32'h0);
    xfer('{8'h7C, 8'h00, 8'h38}, 1'b1);
    xfer('{8'h7C, 8'h00, 8'h39, 8'h14, 8'h74, 8'h54, 8'h6F, 8'h0C, 8'h01}, 1'b1);
    xfer('{8'h7C, 8'h00, 8'h39, 8'h14, 8'h79, 8'h50, 8'h6C, 8'h0C, 8'h01}, 1'b1);
    rdc(`OFS_STATUS, 32'h7000);
    rdc(`OFS_BYTES, 32'h15);
    wr(`OFS_BYTES, 32'h0);
    // A continued command word sets the pointer, then the last control byte selects data.
    xfer('{8'h7C, 8'h80, 8'h85, 8'h40, 8'h55, 8'h56}, 1'b1);
    rdc(`OFS_STATUS, 32'h7007);
    wr(`OFS_RAM_ADDR, 32'h5);
    rdc(`OFS_RAM_DATA, 32'h55);
    wr(`OFS_RAM_ADDR, 32'h6);
    rdc(`OFS_RAM_DATA, 32'h56);
    rdc(`OFS_BYTES, 32'h6);
    xfer('{8'h7E, 8'h40, 8'h99}, 1'b0);
    xfer('{8'h7D, 8'h40}, 1'b0);
    wr(`OFS_CTRL, 32'h0);
    xfer('{8'h7C, 8'h00}, 1'b0);
    wr(`OFS_CTRL, 32'h1);
    rdc(`OFS_BYTES, 32'h6);
    // Glyph addressing with a decrementing entry mode, then a return home.
    xfer('{8'h7C, 8'h80, 8'h38, 8'h80, 8'h04, 8'h80, 8'h43, 8'h40, 8'h66, 8'h67}, 1'b1);
    rdc(`OFS_STATUS, 32'h4101);
    wr(`OFS_RAM_ADDR, 32'h83);
    rdc(`OFS_RAM_DATA, 32'h66);
    wr(`OFS_RAM_ADDR, 32'h82);
    rdc(`OFS_RAM_DATA, 32'h67);
    xfer('{8'h7C, 8'h00, 8'h02}, 1'b1);
    rdc(`OFS_STATUS, 32'h4000);
    rdc(`OFS_BYTES, 32'h13);
    check("sda_out", {31'h0, sda_out}, 32'h0);
    results();
  end
endmodule
